// File: hdl/intprio_defines.svh
`ifndef INTPRIO_DEFINES_SVH
`define INTPRIO_DEFINES_SVH

// bank size and field geometry
`define NUM_SRC       11
`define FLD_W         3
`define SRC_W         4
`define LVL_W         4
`define REG_W         16
`define ADDR_W        7
`define IDX_W         5

// field values
`define PRIO_RESET    3'h4
`define PRIO_OFF      3'h0

// register word index, byte address is index times four
`define IDX_CTL_8     5'h08
`define IDX_CTL_9     5'h09
`define IDX_CTL_12    5'h0c
`define IDX_CTL_15    5'h0f
`define IDX_CTL_16    5'h10
`define IDX_CTL_18    5'h12
`define IDX_CTL_19    5'h13

// source numbers, also the arbitration tie order
`define SRC_SP2_FAULT 0
`define SRC_SP2_EVENT 1
`define SRC_CAPTURE3  2
`define SRC_TW2_SLAVE 3
`define SRC_TW2_MSTR  4
`define SRC_CLK_CAL   5
`define SRC_UART1_ERR 6
`define SRC_UART2_ERR 7
`define SRC_CRC_ERR   8
`define SRC_VOLT_DET  9
`define SRC_CHG_TIME  10

// low bit of each field inside its register
`define LO_BITS_2_0   0
`define LO_BITS_6_4   4
`define LO_BITS_10_8  8
`define LO_BITS_14_12 12

// byte lane split inside a 16-bit register
`define LANE1_LO      8

`endif

// File: hdl/intprio_pkg.sv
`include "intprio_defines.svh"

package intprio_pkg;

  typedef enum logic {
    PH_IDLE,
    PH_ANSWER
  } phase_e;

  typedef logic [`NUM_SRC-1:0][`FLD_W-1:0] fields_t;

  typedef struct packed {
    logic              active;
    logic [`FLD_W-1:0] level;
    logic [`SRC_W-1:0] source;
  } arb_s;

  typedef struct packed {
    phase_e      phase;
    logic        waitreq;
    logic [31:0] rdata;
    fields_t     fields;
    arb_s        arb;
  } state_s;

endpackage : intprio_pkg

// File: hdl/interrupt_priority_fields_bank.sv
`timescale 1ns/1ps
`include "intprio_defines.svh"

// Summary of operation
// R1 - three-bit field, code 111 gives level 7, the highest user level
// R2 - code 001 gives level 1; codes between map linearly to levels 2-6
// R3 - code 000 disables the source; it never requests, whatever its flag
// R4 - unassigned register bits read zero and ignore writes
// R5 - every field resets to 100, level 4
// R6 - every field is read/write and reads back the last value written
// R7 - serial port 2 event field at bits 6-4 of register 8
// R8 - serial port 2 fault field at bits 2-0 of register 8
// R9 - capture 3 field at bits 6-4 of register 9, rest unused
// R10 - two-wire 2 master field at bits 10-8 of register 12
// R11 - two-wire 2 slave field at bits 6-4 of register 12
// R12 - clock/calendar field at bits 10-8 of register 15
// R13 - crc error field at bits 14-12 of register 16
// R14 - uart 2 error field at bits 10-8 of register 16
// R15 - uart 1 error field at bits 6-4 of register 16
// R16 - voltage detect field at bits 2-0 of register 18
// R17 - charge time unit field at bits 6-4 of register 19
// R18 - a pending source requests only when its level exceeds the cpu level
// R19 - fields drive the arbitration continuously; writes act next cycle

module interrupt_priority_fields_bank (
  input  wire logic [0:0]           ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic [`ADDR_W-1:0]   address_i,
  input  wire logic                 read_i,
  input  wire logic                 write_i,
  input  wire logic [31:0]          writedata_i,
  input  wire logic [3:0]           byteenable_i,
  output logic      [31:0]          readdata_o,
  output logic                      waitrequest_o,
  input  wire logic [`NUM_SRC-1:0]  pending_i,
  input  wire logic [`LVL_W-1:0]    cpu_level_i,
  output intprio_pkg::fields_t      fields_o,
  output intprio_pkg::arb_s         request_o
);

  import intprio_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // field placement tables

  function automatic logic [`IDX_W-1:0] src_reg(input int src);
    case (src)
      `SRC_SP2_FAULT: src_reg = `IDX_CTL_8;     // R8
      `SRC_SP2_EVENT: src_reg = `IDX_CTL_8;     // R7
      `SRC_CAPTURE3:  src_reg = `IDX_CTL_9;     // R9
      `SRC_TW2_SLAVE: src_reg = `IDX_CTL_12;    // R11
      `SRC_TW2_MSTR:  src_reg = `IDX_CTL_12;    // R10
      `SRC_CLK_CAL:   src_reg = `IDX_CTL_15;    // R12
      `SRC_UART1_ERR: src_reg = `IDX_CTL_16;    // R15
      `SRC_UART2_ERR: src_reg = `IDX_CTL_16;    // R14
      `SRC_CRC_ERR:   src_reg = `IDX_CTL_16;    // R13
      `SRC_VOLT_DET:  src_reg = `IDX_CTL_18;    // R16
      `SRC_CHG_TIME:  src_reg = `IDX_CTL_19;    // R17
      default:        src_reg = `IDX_CTL_8;
    endcase
  endfunction : src_reg

  function automatic int src_lo(input int src);
    case (src)
      `SRC_SP2_FAULT: src_lo = `LO_BITS_2_0;    // R8
      `SRC_SP2_EVENT: src_lo = `LO_BITS_6_4;    // R7
      `SRC_CAPTURE3:  src_lo = `LO_BITS_6_4;    // R9
      `SRC_TW2_SLAVE: src_lo = `LO_BITS_6_4;    // R11
      `SRC_TW2_MSTR:  src_lo = `LO_BITS_10_8;   // R10
      `SRC_CLK_CAL:   src_lo = `LO_BITS_10_8;   // R12
      `SRC_UART1_ERR: src_lo = `LO_BITS_6_4;    // R15
      `SRC_UART2_ERR: src_lo = `LO_BITS_10_8;   // R14
      `SRC_CRC_ERR:   src_lo = `LO_BITS_14_12;  // R13
      `SRC_VOLT_DET:  src_lo = `LO_BITS_2_0;    // R16
      `SRC_CHG_TIME:  src_lo = `LO_BITS_6_4;    // R17
      default:        src_lo = `LO_BITS_2_0;
    endcase
  endfunction : src_lo

  ////////////////////////////////////////////////////////////////////////
  // state

  localparam state_s ST_RESET = '{
    phase:   PH_IDLE,
    waitreq: 1'b1,
    rdata:   32'h00000000,
    fields:  {`NUM_SRC{`PRIO_RESET}},         // R5
    arb:     '0
  };

  state_s st_r;
  state_s st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // per-source decode, readback and arbitration chain

  logic [`IDX_W-1:0]  word_idx;
  logic               commit;
  fields_t            fld_nxt;
  logic [`REG_W-1:0]  contrib  [0:`NUM_SRC-1];
  logic [`REG_W-1:0]  rd_or    [0:`NUM_SRC];
  logic               best_any [0:`NUM_SRC];
  logic [`FLD_W-1:0]  best_lvl [0:`NUM_SRC];
  logic [`SRC_W-1:0]  best_src [0:`NUM_SRC];
  logic [`NUM_SRC-1:0] elig;
  arb_s               arb_win;

  // word aligned; the two low address bits are not decoded
  assign word_idx = address_i[`ADDR_W-1:2];

  // writes land at the edge where the master sees waitrequest low
  assign commit = (st_r.phase == PH_ANSWER) && write_i;

  assign rd_or[0]    = '0;
  assign best_any[0] = 1'b0;
  assign best_lvl[0] = `PRIO_OFF;
  assign best_src[0] = '0;

  for (genvar i = 0; i < `NUM_SRC; i++) begin : g_src
    localparam logic [`IDX_W-1:0] RIDX = src_reg(i);
    localparam int                LO   = src_lo(i);
    localparam int                LANE = (LO >= `LANE1_LO) ? 1 : 0;

    logic              hit;
    logic [`FLD_W-1:0] fld;
    logic              take;

    assign hit = (word_idx == RIDX);
    assign fld = st_r.fields[i];

    // only field bits are placed; every other bit stays zero
    assign contrib[i] = hit ? (`REG_W'(fld) << LO) : '0;  // R4 R6
    assign rd_or[i+1] = rd_or[i] | contrib[i];

    // byte lane must be enabled for the field to take the data
    assign fld_nxt[i] = (commit && hit && byteenable_i[LANE])
                        ? writedata_i[LO +: `FLD_W]   // R6
                        : fld;

    // zero code never competes; higher code means higher level
    assign elig[i] = pending_i[i]
                     && (fld != `PRIO_OFF)              // R3
                     && ({1'b0, fld} > cpu_level_i);  // R1 R2 R18

    // strict compare keeps the lower source number on a tie
    assign take = elig[i] && (!best_any[i] || (fld > best_lvl[i]));

    assign best_any[i+1] = best_any[i] | elig[i];
    assign best_lvl[i+1] = take ? fld : best_lvl[i];
    assign best_src[i+1] = take ? `SRC_W'(i) : best_src[i];
  end

  assign arb_win.active = best_any[`NUM_SRC];
  assign arb_win.level  = best_lvl[`NUM_SRC];
  assign arb_win.source = best_src[`NUM_SRC];

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt     = st_r;
    // arbitration sees the stored fields, so a write shows a cycle later
    st_nxt.arb = arb_win;                          // R19
    case (st_r.phase)
      PH_IDLE: begin
        st_nxt.waitreq = 1'b1;
        if (read_i || write_i) begin
          st_nxt.phase   = PH_ANSWER;
          st_nxt.waitreq = 1'b0;
          // unmapped words read as zero
          if (read_i) begin
            st_nxt.rdata = {16'h0000, rd_or[`NUM_SRC]};  // R4
          end
        end
      end
      PH_ANSWER: begin
        st_nxt.phase   = PH_IDLE;
        st_nxt.waitreq = 1'b1;
        st_nxt.fields  = fld_nxt;                  // R6
      end
      default: begin
        st_nxt = ST_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_r <= ST_RESET;                            // R5
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign readdata_o    = st_r.rdata;
  assign waitrequest_o = st_r.waitreq;
  assign fields_o      = st_r.fields;              // R19
  assign request_o     = st_r.arb;

endmodule : interrupt_priority_fields_bank

// File: sim/intprio_sva.sv
`timescale 1ns/1ps
`include "intprio_defines.svh"
module intprio_sva (
  input wire logic [0:0]          ref_clk_i,
  input wire logic                reset_i,
  input wire logic [6:0]          address_i,
  input wire logic                read_i,
  input wire logic                write_i,
  input wire logic [31:0]         writedata_i,
  input wire logic [3:0]          byteenable_i,
  input wire logic [31:0]         readdata_o,
  input wire logic                waitrequest_o,
  input wire logic [10:0]         pending_i,
  input wire logic [3:0]          cpu_level_i,
  input wire intprio_pkg::fields_t fields_o,
  input wire intprio_pkg::arb_s    request_o
);
  import intprio_pkg::*;
  fields_t     pf_r;
  logic [10:0] pp_r;
  logic [3:0]  pl_r;
  // what the arbiter saw one edge back
  always_ff @(posedge ref_clk_i) begin
    pf_r <= fields_o;
    pp_r <= pending_i;
    pl_r <= cpu_level_i;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  chk_wait_answer: assert property ((read_i | write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("no answer");
  chk_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("wait low too long");
  chk_upper_zero: assert property (!waitrequest_o |-> readdata_o[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_reset_val: assert property ($fell(reset_i) |-> fields_o == {11{3'h4}} && !request_o.active)
    else $error("bad reset value");
  chk_req_field: assert property (request_o.active |-> request_o.level == pf_r[request_o.source]
    && request_o.level != 3'h0) else $error("request level wrong");
  chk_above_cpu: assert property (request_o.active |-> pp_r[request_o.source]
    && {1'b0, request_o.level} > pl_r) else $error("request not above cpu");
  chk_no_pend: assert property (pp_r == 11'h0 |-> !request_o.active)
    else $error("request without flag");
  chk_write_spi: assert property (write_i && !waitrequest_o && address_i[6:2] == `IDX_CTL_8
    && byteenable_i[0] |=> fields_o[1] == $past(writedata_i[6:4])) else $error("reg8 write");
  chk_write_crc: assert property (write_i && !waitrequest_o && address_i[6:2] == `IDX_CTL_16
    && byteenable_i[1] |=> fields_o[8] == $past(writedata_i[14:12])) else $error("reg16 write");
  chk_fields_hold: assert property (waitrequest_o |=> $stable(fields_o))
    else $error("field moved without write");
endmodule : intprio_sva

// File: sim/arb_partner.sv
`timescale 1ns/1ps
module arb_partner (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic [10:0] want_pend_i,
  input  wire logic [3:0]  want_level_i,
  output logic      [10:0] pending_o = 11'h0,
  output logic      [3:0]  cpu_level_o = 4'h0
);
  // flags and cpu level only move on the system clock, like the real sources
  always @(posedge ref_clk_i) begin
    pending_o <= reset_i ? 11'h0 : want_pend_i;
    cpu_level_o <= reset_i ? 4'h0 : want_level_i;
  end
endmodule : arb_partner

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import intprio_pkg::*;
  logic ref_clk_i = 0, reset_i = 1, read_i = 0, write_i = 0, waitrequest_o;
  logic [6:0] address_i = 0;
  logic [31:0] writedata_i = 0, readdata_o, lfsr = 32'hb683;
  logic [3:0] byteenable_i = 0, cpu_level_i, want_lvl = 0;
  logic [10:0] pending_i, want_pend = 0;
  fields_t fields_o;
  arb_s request_o;
  int n_fail = 0, tests_run = 0, m[11], rl[7] = '{8, 9, 12, 15, 16, 18, 19};
  int ix[11] = '{8, 8, 9, 12, 12, 15, 16, 16, 16, 18, 19};
  int lo[11] = '{0, 4, 4, 4, 8, 8, 4, 8, 12, 0, 4};
  interrupt_priority_fields_bank interrupt_priority_fields_bank_i (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .pending_i(pending_i), .cpu_level_i(cpu_level_i),
    .fields_o(fields_o), .request_o(request_o));
  arb_partner arb_partner_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .want_pend_i(want_pend),
    .want_level_i(want_lvl), .pending_o(pending_i), .cpu_level_o(cpu_level_i));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
    return lfsr;
  endfunction : rnd
  task automatic chk(string n, logic [32:0] e, logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic bus(logic we, int i, logic [31:0] d, logic [3:0] be);
    logic [32:0] v;
    v = 0;
    @(posedge ref_clk_i);
    address_i <= 7'(i * 4);
    read_i <= !we;
    write_i <= we;
    writedata_i <= d;
    byteenable_i <= be;
    do @(posedge ref_clk_i); while (waitrequest_o !== 1'b0);
    read_i <= 0;
    write_i <= 0;
    for (int s = 0; s < 11; s++) begin
      if (we && ix[s] == i && be[lo[s] / 8]) m[s] = d[lo[s] +: 3];
      if (ix[s] == i) v[lo[s] +: 3] = m[s][2:0];
    end
    if (!we) chk("readdata", v, {1'b0, readdata_o});
  endtask : bus
  task automatic arb();
    int b, w;
    b = 0;
    w = 0;
    @(posedge ref_clk_i);
    want_pend <= 11'(rnd());
    want_lvl <= 4'(rnd());
    // one edge in the partner, one in the arbiter
    repeat (2) @(posedge ref_clk_i);
    #1;
    for (int s = 0; s < 11; s++)
      if (want_pend[s] && m[s] > want_lvl && m[s] > b) begin
        b = m[s];
        w = s;
      end
    chk("active", b != 0, request_o.active);
    if (b != 0) chk("request", {b[2:0], w[3:0]}, {request_o.level, request_o.source});
  endtask : arb
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic sweep(logic we, logic [31:0] d);
    for (int r = 0; r < 7; r++) bus(we, rl[r], d, 4'hf);
    repeat (20) arb();
  endtask : sweep
  initial begin
    #1ms;
    n_fail++;
    results();
  end
  initial begin
    for (int k = 0; k < 2; k++) begin
      foreach (m[s]) m[s] = 4;
      reset_i <= 1;
      repeat (20) @(posedge ref_clk_i);
      reset_i <= 0;
      sweep(0, 0);
    end
    bus(1, 1, 32'hffffffff, 4'hf);
    bus(0, 1, 0, 0);
    sweep(1, 0);
    sweep(1, 32'hffffffff);
    sweep(1, 32'h1111);
    repeat (60) begin
      bus(1, rl[rnd() % 7], rnd(), 4'(rnd()));
      bus(0, rl[rnd() % 7], 0, 0);
      chk("fields", {m[10][2:0], m[9][2:0], m[8][2:0], m[7][2:0], m[6][2:0], m[5][2:0],
        m[4][2:0], m[3][2:0], m[2][2:0], m[1][2:0], m[0][2:0]}, fields_o);
      repeat (4) arb();
    end
    results();
  end
endmodule : testbench
bind interrupt_priority_fields_bank intprio_sva intprio_sva_i (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .pending_i(pending_i), .cpu_level_i(cpu_level_i),
  .fields_o(fields_o), .request_o(request_o));
